/* File: one_wire_brightness_interface.sv */
// one_wire_brightness_interface: mode detect, pwm reference chopping and one-wire decoding
// assumes i_ctrl is synchronous to i_clk; the pin wire is resolved outside from o_ctrl_oe
//
// How it works
// - pwm mode chops full reference, then filtered
// - accepted command picks one of 32 levels
// - enabling loads full-scale code 31
// - level held between commands, reset restores default
// - frame is address byte then data byte
// - data byte: ack flag, zero subaddress, code
// - codes map pseudo-logarithmically up to 200 mV
// - decoder works from 1.7 to 160 kbit/s
// - bits assembled most significant first
// - 2 us end-of-stream low closes each byte
// - bit value from twice-longer high or low
// - bit measured falling edge to falling edge
// - acknowledge only on request, match, 16 good bits
// - pull-down after delay, at most 512 us
// - one-wire entry by high-then-long-low pattern
// - low beyond 2.5 ms shuts device down
`timescale 1ns/10ps

module one_wire_brightness_interface
    import brightness_pkg::*;
#(
    parameter logic [7:0]       DEVICE_ADDRESS = DEV_ADDR_DEF,
    parameter logic [CNT_W-1:0] MODE_LOW_CYC   = MODE_LOW_CYC_DEF,
    parameter logic [CNT_W-1:0] MODE_WIN_CYC   = MODE_WIN_CYC_DEF,
    parameter logic [CNT_W-1:0] SHUTDOWN_CYC   = SHUTDOWN_CYC_DEF,
    parameter logic [CNT_W-1:0] ACK_PULSE_CYC  = ACK_PULSE_CYC_DEF,
    parameter int               FILT_SHIFT     = FILT_SHIFT_DEF
) (
    // clock and reset
    input  wire logic    i_clk,
    input  wire logic    i_rst_n,
    // control pin, open drain
    input  wire logic    i_ctrl,
    output logic         o_ctrl_out,
    output logic         o_ctrl_oe,
    // regulation side
    output logic         o_ref_gate,
    output status_t      o_status
);

    // ------------------------------------------------------------
    // pin edges and timers
    // ------------------------------------------------------------
    localparam int ACK_W = int'(ACK_WAIT_CYC);

    state_t             state_q, state_d;
    logic               ctrl_q;
    logic [CNT_W-1:0]   cnt_q, tmr_q, low_len_q;
    logic [15:0]        shift_q;
    logic [2:0]         bits_q;
    logic               byte_q, err_q, low_ok_q, gate_q;
    logic [4:0]         level_q;
    logic [15:0]        filt_q;
    logic [7:0]         fb_ref_q;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (&v) ? v : v + CNT_W'(1);
    endfunction

    wire fall = ctrl_q & ~i_ctrl;
    wire rise = ~ctrl_q & i_ctrl;
    wire [CNT_W-1:0] high_len = sat_inc(cnt_q);
    wire bit_one  = {1'b0, high_len} >= {low_len_q, 1'b0};
    wire bit_zero = {1'b0, low_len_q} >= {high_len, 1'b0};
    wire ambiguous = ~bit_one & ~bit_zero;
    wire pwm_mode = (state_q == ST_DETECT) | (state_q == ST_PWM);
    wire enabling = (state_q == ST_OFF) & rise;
    // on the fall cycle cnt_q still holds the high time, so the previous sample must be low too
    wire shut = (state_q != ST_OFF) & ~ctrl_q & ~i_ctrl
              & (cnt_q >= SHUTDOWN_CYC - CNT_W'(1));
    wire commit = (state_q == ST_OW_EOS) & byte_q & ~i_ctrl
                & (cnt_q == EOS_CYC - CNT_W'(1));
    wire frame_ok = ~err_q & (shift_q[15:8] == DEVICE_ADDRESS)
                  & (shift_q[6:5] == 2'b00);
    wire ack_go = frame_ok & shift_q[7];
    wire eos_short = cnt_q < EOS_CYC - CNT_W'(1);
    wire start_short = cnt_q < START_CYC - CNT_W'(1);
    wire [15:0] target = pwm_mode & gate_q ? {REF_FULL_MV, 8'h00} : 16'h0000;
    wire [15:0] filt_up = filt_q + ((target - filt_q) >> FILT_SHIFT);
    wire [15:0] filt_dn = filt_q - ((filt_q - target) >> FILT_SHIFT);

    // ------------------------------------------------------------
    // mode and frame state machine
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (rise) begin
                    state_d = ST_DETECT;
                end
            end
            ST_DETECT: begin
                if (tmr_q >= MODE_WIN_CYC) begin
                    state_d = ST_PWM;
                end else if (~i_ctrl & low_ok_q & (cnt_q >= MODE_LOW_CYC)) begin
                    state_d = ST_OW_IDLE;
                end
            end
            ST_PWM: begin
                state_d = ST_PWM;
            end
            ST_OW_IDLE, ST_OW_START: begin
                if (fall) begin
                    state_d = ST_OW_LOW;
                end
            end
            ST_OW_LOW: begin
                if (rise) begin
                    state_d = ST_OW_HIGH;
                end
            end
            ST_OW_HIGH: begin
                if (fall) begin
                    state_d = (bits_q == 3'h7) ? ST_OW_EOS : ST_OW_LOW;
                end
            end
            ST_OW_EOS: begin
                if (rise) begin
                    state_d = byte_q ? ST_OW_IDLE : ST_OW_START;
                end else if (commit) begin
                    state_d = ack_go ? ST_OW_ACKW : ST_OW_IDLE;
                end
            end
            ST_OW_ACKW: begin
                if (tmr_q == ACK_WAIT_CYC - CNT_W'(1)) begin
                    state_d = ST_OW_ACK;
                end
            end
            ST_OW_ACK: begin
                if (tmr_q == ACK_PULSE_CYC - CNT_W'(1)) begin
                    state_d = ST_OW_IDLE;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        if (shut) begin
            state_d = ST_OFF;
        end
    end

    // pulse widths are counted at the system clock rate
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_q <= ST_OFF;
            ctrl_q  <= 1'b0;
            cnt_q   <= '0;
            tmr_q   <= '0;
        end else begin
            state_q <= state_d;
            ctrl_q  <= i_ctrl;
            cnt_q   <= (fall | rise) ? '0 : sat_inc(cnt_q);
            tmr_q   <= (state_d != state_q) ? '0 : sat_inc(tmr_q);
        end
    end

    // ------------------------------------------------------------
    // bit assembly
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            low_len_q <= '0;
            shift_q   <= 16'h0000;
            bits_q    <= 3'h0;
            byte_q    <= 1'b0;
            err_q     <= 1'b0;
            low_ok_q  <= 1'b0;
        end else begin
            if (state_q == ST_DETECT && fall) begin
                low_ok_q <= tmr_q >= MODE_DELAY_CYC;
            end else if (rise) begin
                low_ok_q <= 1'b0;
            end
            if (state_q == ST_OW_LOW && rise) begin
                low_len_q <= high_len;
            end
            if (state_q == ST_OW_IDLE && fall) begin
                bits_q <= 3'h0;
                byte_q <= 1'b0;
                err_q  <= 1'b0;
            end else if (state_q == ST_OW_START && fall) begin
                bits_q <= 3'h0;
                byte_q <= 1'b1;
                err_q  <= err_q | start_short;
            end else if (state_q == ST_OW_HIGH && fall) begin
                shift_q <= {shift_q[14:0], bit_one};
                bits_q  <= bits_q + 3'h1;
                err_q   <= err_q | ambiguous;
            end else if (state_q == ST_OW_EOS && rise && !byte_q) begin
                err_q <= err_q | eos_short;
            end
        end
    end

    // ------------------------------------------------------------
    // level register and reference
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            level_q <= LEVEL_DEFAULT;
        end else if (enabling) begin
            level_q <= LEVEL_DEFAULT;
        end else if (commit && frame_ok) begin
            level_q <= shift_q[4:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            gate_q   <= 1'b0;
            filt_q   <= 16'h0000;
            fb_ref_q <= 8'h00;
        end else begin
            gate_q <= pwm_mode & i_ctrl;
            filt_q <= (target >= filt_q) ? filt_up : filt_dn;
            if (state_q == ST_OFF) begin
                fb_ref_q <= 8'h00;
            end else if (pwm_mode) begin
                fb_ref_q <= filt_q[15:8];
            end else begin
                fb_ref_q <= level_to_mv(level_q);
            end
        end
    end

    assign o_ctrl_out         = 1'b0;
    assign o_ctrl_oe          = (state_q == ST_OW_ACK);
    assign o_ref_gate         = gate_q;
    assign o_status.enabled   = (state_q != ST_OFF);
    assign o_status.one_wire  = ~pwm_mode & (state_q != ST_OFF);
    assign o_status.level     = level_q;
    assign o_status.fb_ref_mv = fb_ref_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_ack_wait;
        !o_ctrl_oe ##ACK_W o_ctrl_oe;
    endsequence
    property p_pwm_gate;
        @(posedge i_clk) disable iff (!i_rst_n) (pwm_mode && i_ctrl && !shut) |=> o_ref_gate;
    endproperty
    a_pwm_gate: assert property (p_pwm_gate) else $error("gate not following pin");
    property p_level_default;
        @(posedge i_clk) disable iff (!i_rst_n) enabling |=> (level_q == LEVEL_DEFAULT);
    endproperty
    a_level_default: assert property (p_level_default) else $error("no default");
    property p_level_hold;
        @(posedge i_clk) disable iff (!i_rst_n) (!enabling && !commit) |=> $stable(level_q);
    endproperty
    a_level_hold: assert property (p_level_hold) else $error("level changed");
    property p_commit;
        @(posedge i_clk) disable iff (!i_rst_n)
            (commit && frame_ok) |=> (level_q == $past(shift_q[4:0]));
    endproperty
    a_commit: assert property (p_commit) else $error("code not taken");
    property p_reject;
        @(posedge i_clk) disable iff (!i_rst_n) (commit && !frame_ok) |=> $stable(level_q);
    endproperty
    a_reject: assert property (p_reject) else $error("bad frame taken");
    property p_ack_timing;
        @(posedge i_clk) disable iff (!i_rst_n) (commit && ack_go && !shut) |=> s_ack_wait;
    endproperty
    a_ack_timing: assert property (p_ack_timing) else $error("ack late or early");
    property p_ack_len;
        @(posedge i_clk) disable iff (!i_rst_n) o_ctrl_oe |-> (tmr_q < ACK_PULSE_CYC);
    endproperty
    a_ack_len: assert property (p_ack_len) else $error("ack too long");
    property p_ack_cause;
        @(posedge i_clk) disable iff (!i_rst_n) (commit && !ack_go) |=> !o_ctrl_oe[*2];
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("unwanted ack");
    property p_shutdown;
        @(posedge i_clk) disable iff (!i_rst_n) shut |=> !o_status.enabled;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("no shutdown");
    property p_window;
        @(posedge i_clk) disable iff (!i_rst_n)
            (state_q == ST_DETECT && tmr_q >= MODE_WIN_CYC && !shut) |=> (state_q == ST_PWM);
    endproperty
    a_window: assert property (p_window) else $error("window not closed");
    property p_msb_first;
        @(posedge i_clk) disable iff (!i_rst_n) (state_q == ST_OW_HIGH && fall)
            |=> (shift_q == {$past(shift_q[14:0]), $past(bit_one)});
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("bit order");

endmodule

/* File: brightness_pkg.sv */
// brightness_pkg: constants, types and the level map for the one-wire brightness block
// assumes a 20 MHz system clock; all times are converted to cycles here
package brightness_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int CNT_W         = 17;

    localparam int T_MODE_DELAY_NS = 100000;
    localparam int T_MODE_LOW_NS   = 260000;
    localparam int T_MODE_WIN_NS   = 1000000;
    localparam int T_SHUTDOWN_NS   = 2500000;
    localparam int END_OF_STREAM_TIME_NS        = 2000;
    localparam int T_START_NS      = 2000;
    localparam int T_ACK_VALID_NS  = 4000;
    localparam int T_ACK_PULSE_NS  = 512000;

    // least times round up, longest times round down
    localparam logic [CNT_W-1:0] MODE_DELAY_CYC =
        CNT_W'((T_MODE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] MODE_LOW_CYC_DEF =
        CNT_W'((T_MODE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] MODE_WIN_CYC_DEF = CNT_W'(T_MODE_WIN_NS / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SHUTDOWN_CYC_DEF =
        CNT_W'((T_SHUTDOWN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] EOS_CYC =
        CNT_W'((END_OF_STREAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] START_CYC =
        CNT_W'((T_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACK_VALID_CYC =
        CNT_W'((T_ACK_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ACK_WAIT_CYC = ACK_VALID_CYC - EOS_CYC;
    localparam logic [CNT_W-1:0] ACK_PULSE_CYC_DEF = CNT_W'(T_ACK_PULSE_NS / CLK_PERIOD_NS);

    // ------------------------------------------------------------
    // frame and level values
    // ------------------------------------------------------------
    localparam logic [7:0] DEV_ADDR_DEF  = 8'h5a;  // arbitrary value
    localparam logic [4:0] LEVEL_DEFAULT = 5'h1f;
    localparam logic [7:0] REF_FULL_MV   = 8'hc8;
    localparam int         FILT_SHIFT_DEF = 6;
    localparam logic [4:0] LVL_BRK1      = 5'h0c;
    localparam logic [4:0] LVL_BRK2      = 5'h17;
    localparam logic [7:0] LVL_FIRST_MV  = 8'h05;
    localparam logic [7:0] LVL_BRK1_MV   = 8'h26;
    localparam logic [7:0] LVL_BRK2_MV   = 8'h68;
    localparam logic [7:0] LVL_STEP1     = 8'h03;
    localparam logic [7:0] LVL_STEP2     = 8'h06;
    localparam logic [7:0] LVL_STEP3     = 8'h0c;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [9:0] {
        ST_OFF     = 10'h001,
        ST_DETECT  = 10'h002,
        ST_PWM     = 10'h004,
        ST_OW_IDLE = 10'h008,
        ST_OW_START = 10'h010,
        ST_OW_LOW  = 10'h020,
        ST_OW_HIGH = 10'h040,
        ST_OW_EOS  = 10'h080,
        ST_OW_ACKW = 10'h100,
        ST_OW_ACK  = 10'h200
    } state_t;

    typedef struct packed {
        logic       enabled;
        logic       one_wire;
        logic [4:0] level;
        logic [7:0] fb_ref_mv;
    } status_t;

    // pseudo-logarithmic code to millivolt map
    function automatic logic [7:0] level_to_mv(input logic [4:0] code);
        logic [7:0] c;
        c = {3'h0, code};
        if (code == 5'h00) begin
            return 8'h00;
        end else if (code <= LVL_BRK1) begin
            return LVL_FIRST_MV + (c - 8'h01) * LVL_STEP1;
        end else if (code <= LVL_BRK2) begin
            return LVL_BRK1_MV + (c - {3'h0, LVL_BRK1}) * LVL_STEP2;
        end else begin
            return LVL_BRK2_MV + (c - {3'h0, LVL_BRK2}) * LVL_STEP3;
        end
    endfunction

endpackage

/* File: host_model.sv */
// host_model: microcontroller side of the brightness control pin
// assumes the bench resolves the open-drain wire with a pull-up
`timescale 1ns/10ps

module host_model (
    // clock
    input  wire logic i_clk,
    // resolved control line
    input  wire logic i_line,
    // high while the host pulls the line low
    output logic      o_low
);
    logic seen;

    initial o_low = 1'b1;

    // --------------------------------------------------------
    // line primitives
    // --------------------------------------------------------
    // open-drain drive: only ever pulls low or lets go
    task automatic hold(input logic v, input int n);
        o_low <= ~v;
        repeat (n) @(posedge i_clk);
    endtask

    task automatic sample();
        seen = i_line;
    endtask

    // start high, then eight bits msb first; 125 cycles a bit at sc 1, 120 for the amb bit
    task automatic send_byte(input logic [7:0] b, input int amb, input int sc);
        hold(1'b1, 45 * sc);
        for (int i = 7; i >= 0; i--) begin
            if (i == amb) begin
                hold(1'b0, 60 * sc);
                hold(1'b1, 60 * sc);
            end else begin
                hold(1'b0, (b[i] ? 40 : 85) * sc);
                hold(1'b1, (b[i] ? 85 : 40) * sc);
            end
        end
    endtask

    // --------------------------------------------------------
    // frame: address, end of stream, data, final fall left low
    // --------------------------------------------------------
    task automatic frame(input logic [7:0] a, d, input int eos_a, amb, sc);
        send_byte(a, amb, sc);
        hold(1'b0, eos_a);
        send_byte(d, -1, sc);
        hold(1'b0, 0);
    endtask
endmodule

/* File: one_wire_brightness_interface_test.sv */
// one_wire_brightness_interface_test: self-checking bench for the brightness block
// assumes 20 MHz clock and shortened mode, shutdown and acknowledge counts
`timescale 1ns/10ps

module one_wire_brightness_interface_test;
    import brightness_pkg::*;

    localparam int         SHUT      = 3000;
    localparam int         ACK_PULSE = 30;
    localparam logic [7:0] ADDR      = 8'h5a;

    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic [4:0] lvl;
        logic       ack;
    } row_t;

    // ordinary frames, levels never rising so code 0 is last
    localparam row_t ROWS [13] = '{
        '{8'h5a, 8'h9f, 5'h1f, 1'b1}, '{8'h5a, 8'h1e, 5'h1e, 1'b0},
        '{8'h5a, 8'h98, 5'h18, 1'b1}, '{8'h5a, 8'h17, 5'h17, 1'b0},
        '{8'h5b, 8'h80, 5'h17, 1'b0}, '{8'h5a, 8'hd0, 5'h17, 1'b0},
        '{8'h5a, 8'hb0, 5'h17, 1'b0}, '{8'h5a, 8'h10, 5'h10, 1'b0},
        '{8'h5a, 8'h8d, 5'h0d, 1'b1}, '{8'h5a, 8'h0c, 5'h0c, 1'b0},
        '{8'h5a, 8'h02, 5'h02, 1'b0}, '{8'h5a, 8'h81, 5'h01, 1'b1},
        '{8'h5a, 8'h00, 5'h00, 1'b0}
    };

    logic    i_clk;
    logic    i_rst_n;
    logic    i_ctrl;
    logic    o_ctrl_out;
    logic    o_ctrl_oe;
    logic    o_ref_gate;
    status_t o_status;
    logic    host_low;
    int      bad_count;
    int      checks;

    // pull-up wins unless someone pulls low
    assign i_ctrl = ~(host_low | o_ctrl_oe);

    one_wire_brightness_interface #(
        .DEVICE_ADDRESS (ADDR),
        .MODE_LOW_CYC   (CNT_W'(20)),
        .MODE_WIN_CYC   (CNT_W'(2500)),
        .SHUTDOWN_CYC   (CNT_W'(SHUT)),
        .ACK_PULSE_CYC  (CNT_W'(ACK_PULSE)),
        .FILT_SHIFT     (10)
    ) one_wire_brightness_interface_i (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_ctrl     (i_ctrl),
        .o_ctrl_out (o_ctrl_out),
        .o_ctrl_oe  (o_ctrl_oe),
        .o_ref_gate (o_ref_gate),
        .o_status   (o_status)
    );

    host_model host_model_i (
        .i_clk  (i_clk),
        .i_line (i_ctrl),
        .o_low  (host_low)
    );

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    function automatic logic [7:0] mv(input int c);
        if (c == 0) return 8'h00;
        if (c <= 12) return 8'(5 + 3 * (c - 1));
        if (c <= 23) return 8'(38 + 6 * (c - 12));
        return 8'(104 + 12 * (c - 23));
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one frame, then watch the acknowledge window for 200 cycles
    task automatic run_frame(input logic [7:0] a, d, input int eos_a, amb, sc,
                             input logic [4:0] lvl, input logic ack);
        int first;
        int cnt;
        first = 0;
        cnt = 0;
        host_model_i.frame(a, d, eos_a, amb, sc);
        for (int k = 1; k <= 200; k++) begin
            @(negedge i_clk);
            if (o_ctrl_oe === 1'b1) begin
                cnt++;
                if (first == 0) first = k;
            end
            if (k == 102) begin
                host_model_i.sample();
                chk(16'(host_model_i.seen), ack ? 16'h0000 : 16'h0001);
            end
            @(posedge i_clk);
            if (k == 100) host_model_i.hold(1'b1, 0);
        end
        chk(16'(cnt), ack ? 16'(ACK_PULSE) : 16'h0000);
        if (ack) chk(16'(first >= 79 && first <= 83), 16'h0001);
        chk(16'(o_ctrl_out), 16'h0000);
        chk(16'(o_status.level), 16'(lvl));
        chk(16'(o_status.fb_ref_mv), 16'(mv(int'(lvl))));
    endtask

    task automatic enter_ow();
        host_model_i.hold(1'b1, 2050);
        host_model_i.hold(1'b0, 30);
        host_model_i.hold(1'b1, 49);
        @(negedge i_clk);
        chk(16'(o_status.one_wire), 16'h0001);
        chk(16'(o_status.level), 16'h001f);
        @(posedge i_clk);
    endtask

    task automatic shut_down();
        host_model_i.hold(1'b0, SHUT - 10);
        @(negedge i_clk);
        chk(16'(o_status.enabled), 16'h0001);
        @(posedge i_clk);
        host_model_i.hold(1'b0, 20);
        @(negedge i_clk);
        chk(16'(o_status.enabled), 16'h0000);
        chk(16'(o_status.fb_ref_mv), 16'h0000);
        @(posedge i_clk);
    endtask

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        bad_count = 0;
        checks = 0;
        i_rst_n = 1'b0;
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(negedge i_clk);
        chk(16'(o_status.enabled), 16'h0000);
        chk(16'(o_status.level), 16'h001f);
        chk(16'(o_ctrl_oe), 16'h0000);
        @(posedge i_clk);
        enter_ow();
        foreach (ROWS[r]) begin
            run_frame(ROWS[r].a, ROWS[r].d, 45, -1, 1, ROWS[r].lvl, ROWS[r].ack);
        end
        shut_down();
        enter_ow();
        run_frame(ADDR, 8'h85, 450, -1, 10, 5'h05, 1'b1);
        run_frame(ADDR, 8'h83, 45, 3, 1, 5'h05, 1'b0);
        run_frame(ADDR, 8'h83, 20, -1, 1, 5'h05, 1'b0);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        @(negedge i_clk);
        chk(16'(o_status.level), 16'h001f);
        chk(16'(o_status.enabled), 16'h0000);
        @(posedge i_clk);
        i_rst_n <= 1'b1;
        host_model_i.hold(1'b1, 3100);
        @(negedge i_clk);
        chk(16'(o_status.one_wire), 16'h0000);
        chk(16'(o_status.enabled), 16'h0001);
        @(posedge i_clk);
        for (int p = 0; p < 40; p++) begin
            host_model_i.hold(1'b1, 49);
            @(negedge i_clk);
            chk(16'(o_ref_gate), 16'h0001);
            @(posedge i_clk);
            host_model_i.hold(1'b0, 99);
            @(negedge i_clk);
            chk(16'(o_ref_gate), 16'h0000);
            chk(16'(o_status.enabled), 16'h0001);
            @(posedge i_clk);
            host_model_i.hold(1'b1, 50);
        end
        @(negedge i_clk);
        chk(16'(o_status.fb_ref_mv >= 8'h55 && o_status.fb_ref_mv <= 8'h73), 16'h0001);
        @(posedge i_clk);
        shut_down();
        stop_test();
    end
endmodule
